// file: hw/sleep_pkg.sv
// Package with constants and carrier types for the pin-controlled sleep block.
`default_nettype none

package sleep_pkg;

  // Timing figures as printed, and the derived cycle counts at 100 MHz.
  localparam int unsigned CLK_PERIOD_PS      = 10000;
  localparam int unsigned SETUP_BEFORE_NS    = 10;
  localparam int unsigned DONT_CARE_AFTER_NS = 5;
  localparam int unsigned RECOVERY_US        = 2;
  // Least setup time rounds up.
  localparam int unsigned SETUP_CYCLES  = (SETUP_BEFORE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Longest times round down; the don't-care time is never below one cycle.
  localparam int unsigned DC_RAW        = (DONT_CARE_AFTER_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned DONT_CARE_CYCLES = (DC_RAW < 1) ? 1 : DC_RAW;
  localparam int unsigned RECOVERY_CYCLES  = (RECOVERY_US * 1000000) / CLK_PERIOD_PS;
  // Edges from the pin falling to valid outputs that are spent outside the recovery count.
  localparam int unsigned WAKE_PATH_CYCLES = 6;

  // Widths and reset values.
  localparam int unsigned PIN_COUNT  = 8;
  localparam int unsigned CNT_WIDTH  = 16;
  localparam logic        SYNC_RESET_VALUE = 1'b0;

  // Operating phases, one-hot.
  typedef enum logic [2:0] {
    ST_RUN     = 3'h1,
    ST_SLEEP   = 3'h2,
    ST_RECOVER = 3'h4
  } phase_type;

  // One group of user pins as seen by the core logic.
  typedef struct packed {
    logic [PIN_COUNT-1:0] data;
    logic [PIN_COUNT-1:0] oe;
  } pin_group_type;

endpackage

`default_nettype wire

// file: hw/sleep_ctrl.sv
// Pin-controlled sleep block: freezes logic and pins while the sleep pin is high.
//
// Operation
// - Sleep control is optional; when disabled the pin stays an ordinary input.
// - With sleep enabled, pin high means sleep, pin low means normal running.
// - Entering sleep captures and holds all outputs and internal state.
// - An output released to high-impedance at sleep entry stays released throughout.
// - During sleep every input except the sleep pin is ignored.
// - Input hold latches keep each pin at its last level during sleep.
// - With sleep enabled the sleep pin does not feed the logic array.
// - Within 5 ns of the pin rising, inputs become don't-care.
// - After the pin falls, inputs and outputs are valid again within 2 us.
`timescale 1ns/10ps
`default_nettype none

module sleep_ctrl #(
  parameter int unsigned PINS            = sleep_pkg::PIN_COUNT,
  parameter int unsigned RECOVERY_CYCLES = sleep_pkg::RECOVERY_CYCLES
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // Configuration and sleep control
  input  wire logic                        sleep_enable,
  input  wire logic                        sleep_request_pin,
  // Pins from outside
  input  wire logic [PINS-1:0]             pin_in,
  // Core side: pins as the logic sees them, and the core's own drive
  output logic      [PINS-1:0]             core_in,
  output logic                             core_sleep_pin_in,
  input  wire sleep_pkg::pin_group_type    core_out,
  // Pin drivers
  output logic      [PINS-1:0]             pin_out,
  output logic      [PINS-1:0]             pin_oe,
  // Status
  output logic                             core_run,
  output logic                             sleeping,
  output logic                             outputs_valid
);

  typedef struct packed {
    logic [2:0]                    sreq;
    logic [2:0][PINS-1:0]          sin;
    sleep_pkg::phase_type          phase;
    logic [PINS-1:0]               keep_in;
    sleep_pkg::pin_group_type      drive;
    logic [sleep_pkg::CNT_WIDTH-1:0] cnt;
    logic                          pin_level;
  } state_type;

  state_type s_q;
  state_type s_d;

  // Recovery counter type; the exit value is cast on purpose to the counter width.
  typedef logic [sleep_pkg::CNT_WIDTH-1:0] count_type;

  // The recovery count is shortened by the synchroniser and phase latency, so the whole
  // span from the pin falling to valid outputs stays within RECOVERY_CYCLES edges.
  // RECOVERY_CYCLES must be at least WAKE_PATH_CYCLES, or the counter wraps.
  localparam count_type EXIT_COUNT = count_type'(RECOVERY_CYCLES - sleep_pkg::WAKE_PATH_CYCLES);
  // Longest wait in the recovery check, counted from the first stage seeing the pin low.
  localparam int        WAKE_BOUND = int'(RECOVERY_CYCLES) - 1;

  // Filtered view of the sleep pin: a change counts once stages two and three agree.
  function automatic logic settle(input logic a, input logic b, input logic prev);
    settle = (a == b) ? a : prev;
  endfunction

  // Inputs freeze once a raised pin reaches the third stage; the data in that same stage
  // was sampled with the pin and is dropped, so later input changes never reach the core.
  function automatic logic input_frozen(input logic enable, input logic [2:0] stages);
    input_frozen = enable && stages[2];
  endfunction

  // Next-state logic for the whole block.
  always_comb begin
    s_d = s_q;
    s_d.sreq = {s_q.sreq[1:0], sleep_request_pin};
    s_d.sin  = {s_q.sin[1:0], pin_in};
    s_d.pin_level = settle(s_q.sreq[1], s_q.sreq[2], s_q.pin_level);
    case (s_q.phase)
      sleep_pkg::ST_RUN: begin
        if (!input_frozen(sleep_enable, s_q.sreq)) begin
          s_d.keep_in = s_q.sin[2];
        end
        s_d.drive   = core_out;
        if (sleep_enable && s_q.pin_level) begin
          s_d.phase = sleep_pkg::ST_SLEEP;
        end
      end
      sleep_pkg::ST_SLEEP: begin
        // Nothing is sampled here, so held data and enables stay frozen.
        if (!sleep_enable || !s_q.pin_level) begin
          s_d.phase = sleep_pkg::ST_RECOVER;
          s_d.cnt   = '0;
        end
      end
      sleep_pkg::ST_RECOVER: begin
        // Inputs and enables are taken again at once; only the valid flag waits.
        if (!input_frozen(sleep_enable, s_q.sreq)) begin
          s_d.keep_in = s_q.sin[2];
        end
        s_d.drive   = core_out;
        s_d.cnt     = s_q.cnt + 1'b1;
        if (sleep_enable && s_q.pin_level) begin
          s_d.phase = sleep_pkg::ST_SLEEP;
        end else if (s_q.cnt >= EXIT_COUNT) begin
          s_d.phase = sleep_pkg::ST_RUN;
        end
      end
      default: begin
        s_d.phase = sleep_pkg::ST_RUN;
      end
    endcase
  end

  // State register; the phase change back to run never clears held contents.
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.phase <= sleep_pkg::ST_RUN;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from held flops, so they keep their values while asleep.
  assign pin_out  = s_q.drive.data;
  assign pin_oe   = s_q.drive.oe;
  assign core_in  = s_q.keep_in;
  // The array sees the pin only when sleep control is not configured.
  assign core_sleep_pin_in = sleep_enable ? 1'b0 : s_q.pin_level;
  assign sleeping = (s_q.phase == sleep_pkg::ST_SLEEP);
  assign core_run = !sleeping;
  assign outputs_valid = (s_q.phase == sleep_pkg::ST_RUN);

  // Checks.
  property p_enter;
    @(posedge clk) disable iff (reset)
      (s_q.phase == sleep_pkg::ST_RUN && sleep_enable && s_q.pin_level) |=> sleeping;
  endproperty
  a_enter: assert property (p_enter) else $error("Sleep not entered.");

  property p_hold_data;
    @(posedge clk) disable iff (reset)
      (sleeping && $past(sleeping)) |-> $stable(pin_out);
  endproperty
  a_hold_data: assert property (p_hold_data) else $error("Output data moved in sleep.");

  property p_hold_oe;
    @(posedge clk) disable iff (reset)
      (sleeping && $past(sleeping)) |-> $stable(pin_oe);
  endproperty
  a_hold_oe: assert property (p_hold_oe) else $error("Output enable moved in sleep.");

  property p_ignore_in;
    @(posedge clk) disable iff (reset)
      sleeping ##1 sleeping |-> $stable(core_in);
  endproperty
  a_ignore_in: assert property (p_ignore_in) else $error("Input leaked in sleep.");

  property p_keep;
    @(posedge clk) disable iff (reset)
      $rose(sleeping) |-> core_in == $past(s_q.keep_in);
  endproperty
  a_keep: assert property (p_keep) else $error("Hold latch lost level.");

  property p_array;
    @(posedge clk) disable iff (reset)
      sleep_enable |-> !core_sleep_pin_in;
  endproperty
  a_array: assert property (p_array) else $error("Sleep pin fed array.");

  property p_disabled;
    @(posedge clk) disable iff (reset)
      !sleep_enable && !sleeping |=> !sleeping;
  endproperty
  a_disabled: assert property (p_disabled) else $error("Slept while disabled.");

  property p_entry_fast;
    @(posedge clk) disable iff (reset)
      ($rose(s_q.sreq[0]) && sleep_enable && !sleeping) ##1 (sleep_enable && s_q.sreq[0]) [*3]
        |-> ##[0:2] sleeping;
  endproperty
  a_entry_fast: assert property (p_entry_fast) else $error("Entry too slow.");

  property p_recover;
    @(posedge clk) disable iff (reset)
      (sleeping && sleep_enable && $fell(s_q.sreq[0])) |-> ##[1:WAKE_BOUND] (outputs_valid || s_q.sreq[0]);
  endproperty
  a_recover: assert property (p_recover) else $error("Valid too late.");

  property p_resume;
    @(posedge clk) disable iff (reset)
      $fell(sleeping) |-> pin_out == $past(pin_out);
  endproperty
  a_resume: assert property (p_resume) else $error("Contents lost on wake.");

  // Once the raised pin is seen, nothing sampled later may reach the core.
  property p_freeze_early;
    @(posedge clk) disable iff (reset)
      (sleep_enable && s_q.sreq[2]) |=> $stable(core_in);
  endproperty
  a_freeze_early: assert property (p_freeze_early) else $error("Input taken after pin rose.");

  property p_oe_reenable;
    @(posedge clk) disable iff (reset)
      (s_q.phase == sleep_pkg::ST_RECOVER) |=> pin_oe == $past(core_out.oe);
  endproperty
  a_oe_reenable: assert property (p_oe_reenable) else $error("Enables not taken in recovery.");

  property p_in_accept;
    @(posedge clk) disable iff (reset)
      (s_q.phase == sleep_pkg::ST_RECOVER && !(sleep_enable && s_q.sreq[2])) |=> core_in == $past(s_q.sin[2]);
  endproperty
  a_in_accept: assert property (p_in_accept) else $error("Inputs not taken in recovery.");

  c_sleep:   cover property (@(posedge clk) $rose(sleeping));
  c_wake:    cover property (@(posedge clk) $fell(sleeping));
  c_valid:   cover property (@(posedge clk) $rose(outputs_valid));
  c_disable: cover property (@(posedge clk) !sleep_enable && s_q.pin_level);

endmodule

`default_nettype wire

// file: verif/sleep_driver.sv
// Model of the system logic that drives the sleep pin of the block.
`timescale 1ns/10ps
`default_nettype none

module sleep_driver (
  // Clock, reset and request from the bench
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic want_sleep,
  // Pin toward the block
  output logic      sleep_request_pin
);
  logic [1:0] settle_q;

  // The bench sets its pins together with want_sleep, so the pin waits two cycles for them to settle.
  always_ff @(posedge clk) begin
    if (reset) begin
      settle_q <= 2'h0;
    end else begin
      settle_q <= {settle_q[0], want_sleep};
    end
  end
  // The pin falls at once when sleep is no longer wanted.
  assign sleep_request_pin = want_sleep & settle_q[1];
endmodule

`default_nettype wire

// file: verif/pin_controlled_power_down_tb.sv
// Self-checking bench for the pin-controlled sleep block.
`timescale 1ns/10ps
`default_nettype none

module pin_controlled_power_down_tb;
  localparam int unsigned REC = 8;
  logic                     clk, reset, sleep_enable, want_sleep, sleep_pin;
  logic                     core_sleep_pin_in, core_run, sleeping, outputs_valid;
  logic [7:0]               pin_in, core_in, pin_out, pin_oe;
  sleep_pkg::pin_group_type core_out;
  int                       n_errors = 0, comparisons = 0, cycles = 0;

  sleep_ctrl #(.PINS(8), .RECOVERY_CYCLES(REC)) u_dut (.clk(clk), .reset(reset),
    .sleep_enable(sleep_enable), .sleep_request_pin(sleep_pin), .pin_in(pin_in), .core_in(core_in),
    .core_sleep_pin_in(core_sleep_pin_in), .core_out(core_out), .pin_out(pin_out), .pin_oe(pin_oe),
    .core_run(core_run), .sleeping(sleeping), .outputs_valid(outputs_valid));
  sleep_driver u_drv (.clk(clk), .reset(reset), .want_sleep(want_sleep), .sleep_request_pin(sleep_pin));

  // Clock and a hang guard well above the fewer than one hundred cycles the run needs.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Sampling one time unit after the edge lets that edge's updates land first.
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic complete_run;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Sleep and wake with pins and drive changing while asleep.
  task automatic s_sleep;
    int n;
    @(posedge clk) begin
      pin_in <= 8'h5a;
      core_out <= '{data: 8'h3c, oe: 8'hf0};
    end
    wait_cycles(6);
    chk("core_in", 8'h5a, core_in);
    chk("pin_out", 8'h3c, pin_out);
    @(posedge clk) want_sleep <= 1'b1;
    repeat (2) @(posedge clk);
    // The pin is up now; inputs moved one cycle later must not reach the core.
    @(posedge clk) pin_in <= 8'h99;
    n = 0;
    while (sleeping !== 1'b1 && n < 20) begin
      wait_cycles(1);
      n++;
    end
    chk("sleeping", 8'h1, {7'h0, sleeping});
    chk("core_in", 8'h5a, core_in);
    chk("core_run", 8'h0, {7'h0, core_run});
    chk("sleep pin to core", 8'h0, {7'h0, core_sleep_pin_in});
    @(posedge clk) begin
      pin_in <= 8'ha5;
      core_out <= '{data: 8'hc3, oe: 8'h0f};
    end
    wait_cycles(8);
    chk("core_in", 8'h5a, core_in);
    chk("pin_out", 8'h3c, pin_out);
    chk("pin_oe", 8'hf0, pin_oe);
    @(posedge clk) want_sleep <= 1'b0;
    n = 0;
    while (outputs_valid !== 1'b1 && n < 40) begin
      wait_cycles(1);
      n++;
    end
    chk("wake within bound", 8'h1, {7'h0, n <= REC});
    chk("core_run", 8'h1, {7'h0, core_run});
    wait_cycles(6);
    chk("core_in", 8'ha5, core_in);
    chk("pin_oe", 8'h0f, pin_oe);
  endtask

  // With sleep not selected the pin is an ordinary input.
  task automatic s_disabled;
    @(posedge clk) sleep_enable <= 1'b0;
    @(posedge clk) want_sleep <= 1'b1;
    wait_cycles(8);
    chk("sleeping", 8'h0, {7'h0, sleeping});
    chk("sleep pin to core", 8'h1, {7'h0, core_sleep_pin_in});
    @(posedge clk) want_sleep <= 1'b0;
    wait_cycles(6);
  endtask

  // Main sequence.
  initial begin
    reset = 1'b1;
    sleep_enable = 1'b1;
    want_sleep = 1'b0;
    pin_in = 8'h00;
    core_out = '0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    wait_cycles(1);
    chk("pin_oe", 8'h00, pin_oe);
    chk("outputs_valid", 8'h1, {7'h0, outputs_valid});
    s_sleep();
    s_disabled();
    complete_run();
  end
endmodule

`default_nettype wire
